//--- logic/bpc_params.svh
// constants of the boost pwm control block: offsets, fields, resets, timing
// assumes inclusion by bare name from the design files of this block
`ifndef BPC_PARAMS_SVH
`define BPC_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define BPC_OFF_CTRL 12'h000
`define BPC_OFF_TARGET 12'h004
`define BPC_OFF_PROT 12'h008
`define BPC_OFF_STATUS 12'h00c
`define BPC_OFF_IRQ_STAT 12'h010
`define BPC_OFF_IRQ_MASK 12'h014

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BPC_CTRL_EN 0
`define BPC_CTRL_SRC 1
`define BPC_CTRL_INV 2
`define BPC_CTRL_FREQ_LSB 8
`define BPC_PROT_MARGIN_LSB 0
`define BPC_PROT_HYST_LSB 4
`define BPC_PROT_SLOPE_LSB 8
`define BPC_PROT_ILIM_LSB 12
`define BPC_STAT_RUN 0
`define BPC_STAT_OVF 1
`define BPC_STAT_SHUT 2
`define BPC_IRQ_OV 0
`define BPC_IRQ_ILIM 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BPC_CTRL_RST 32'h0000_0000
`define BPC_TARGET_RST 7'h00
`define BPC_PROT_RST 32'h0000_0000
`define BPC_IRQ_MASK_RST 2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BPC_CLK_KHZ 40000
`define BPC_FREQ_MAX_KHZ 1000
`define BPC_FREQ_MIN_KHZ 210
`define BPC_DEBOUNCE_CYCLES 2

`endif

//--- logic/bpc_pkg.sv
// types shared by the boost pwm control block
// assumes nothing beyond a systemverilog compiler
package bpc_pkg;

  // protection state, one-hot
  typedef enum logic [1:0] {
    BPC_ST_RUN = 2'b01,
    BPC_ST_SHUT = 2'b10
  } bpc_state_t;

endpackage : bpc_pkg

//--- logic/bpc_sync_filter.sv
// edge debounce for the external sync input
// assumes the raw input is already synchronous to clk
`timescale 1ns/1ps
`include "bpc_params.svh"

module bpc_sync_filter #(
  parameter int DEB = `BPC_DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [DEB-1:0] hist_reg;
  logic level_reg;
  logic rise_reg;
  logic fall_reg;
  wire stable_hi = &hist_reg;
  wire stable_lo = ~|hist_reg;
  wire level_next = stable_hi ? 1'b1 : (stable_lo ? 1'b0 : level_reg);
  wire [DEB-1:0] hist_next = {hist_reg[DEB-2:0], raw};

  // a level is accepted only after DEB equal samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_reg <= '0;
      level_reg <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      hist_reg <= hist_next;
      level_reg <= level_next;
      rise_reg <= level_next & ~level_reg;
      fall_reg <= ~level_next & level_reg;
    end
  end

  assign level = level_reg;
  assign rise = rise_reg;
  assign fall = fall_reg;

  AST_DEB_STABLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(level_reg) |-> $past(stable_hi))
    else $error("sync level rose without stable samples");

endmodule : bpc_sync_filter

//--- logic/bpc_top.sv
// boost pwm control: timing source, gate gating, overvoltage latch, apb regs
// assumes analog comparators deliver levels synchronous to CLK
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "bpc_params.svh"

module bpc_top #(
  parameter bit LOW_FB_DETECT_EN = 1'b1,
  parameter int FREQ_W = 5,
  parameter int TARGET_W = 7
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic SYNC_IN,
  input wire logic OV_ABOVE,
  input wire logic REACT_BELOW,
  input wire logic LOW_FB,
  input wire logic PEAK_REACHED,
  input wire logic ILIM_REACHED,
  output logic GATE,
  output logic RUN_STATUS,
  output logic IRQ,
  output logic [TARGET_W-1:0] TARGET_CODE,
  output logic [2:0] OV_MARGIN,
  output logic [1:0] REACT_HYST,
  output logic [1:0] SLOPE_SEL,
  output logic [1:0] ILIM_SEL
);

  // ----------------------------------------------------------------
  // divider constants
  // ----------------------------------------------------------------
  localparam int PER_MIN = `BPC_CLK_KHZ / `BPC_FREQ_MAX_KHZ;
  localparam int PER_MAX = `BPC_CLK_KHZ / `BPC_FREQ_MIN_KHZ;
  localparam int CODE_MAX = (1 << FREQ_W) - 1;
  localparam int PER_STEP = (PER_MAX - PER_MIN) / (CODE_MAX - 1);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] ctrl_next;
  logic [TARGET_W-1:0] target_reg;
  logic [TARGET_W-1:0] target_next;
  logic [31:0] prot_reg;
  logic [31:0] prot_next;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic ovf_reg;
  logic ovf_next;
  bpc_pkg::bpc_state_t state_reg;
  bpc_pkg::bpc_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic gate_reg;
  logic gate_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire hit_ctrl = PADDR == `BPC_OFF_CTRL;
  wire hit_target = PADDR == `BPC_OFF_TARGET;
  wire hit_prot = PADDR == `BPC_OFF_PROT;
  wire hit_status = PADDR == `BPC_OFF_STATUS;
  wire hit_irq_stat = PADDR == `BPC_OFF_IRQ_STAT;
  wire hit_irq_mask = PADDR == `BPC_OFF_IRQ_MASK;
  wire hit_any = hit_ctrl | hit_target | hit_prot | hit_status |
                 hit_irq_stat | hit_irq_mask;
  wire wr = access & PWRITE & hit_any;
  wire rd_status = access & ~PWRITE & hit_status;
  wire [31:0] lane_mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                           {8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [31:0] wmask = PWDATA & lane_mask;

  assign PREADY = 1'b1;
  assign PSLVERR = access & ~hit_any;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire ctl_en = ctrl_reg[`BPC_CTRL_EN];
  wire ctl_src = ctrl_reg[`BPC_CTRL_SRC];
  wire ctl_inv = ctrl_reg[`BPC_CTRL_INV];
  wire [FREQ_W-1:0] freq_code =
    ctrl_reg[`BPC_CTRL_FREQ_LSB +: FREQ_W];

  // ----------------------------------------------------------------
  // timing source
  // ----------------------------------------------------------------
  logic sync_rise;
  logic sync_fall;

  bpc_sync_filter #(
    .DEB(`BPC_DEBOUNCE_CYCLES)
  ) u_sync (
    .clk(CLK),
    .rst_n(RST_N),
    .raw(SYNC_IN),
    .level(),
    .rise(sync_rise),
    .fall(sync_fall)
  );

  wire [FREQ_W-1:0] code_inv = FREQ_W'(CODE_MAX) - freq_code;
  wire [7:0] period_m1 = 8'(PER_MIN - 1) + 8'(code_inv * PER_STEP);
  wire int_run = ~ctl_src & (freq_code != '0);
  wire int_tick = int_run & (cnt_reg == 8'h00);
  wire int_last = int_run & (cnt_reg >= period_m1);
  wire ext_edge = ctl_inv ? sync_fall : sync_rise;
  wire cycle_start = ctl_src ? ext_edge : int_tick;

  // internal divider restarts from zero when stopped or in external mode
  assign cnt_next = !int_run ? 8'h00 :
                    int_last ? 8'h00 : cnt_reg + 8'h01;

  // ----------------------------------------------------------------
  // protection
  // ----------------------------------------------------------------
  wire low_fb_hit = LOW_FB_DETECT_EN & LOW_FB;
  wire ov_event = OV_ABOVE | low_fb_hit;
  wire in_run = state_reg == bpc_pkg::BPC_ST_RUN;
  wire in_shut = state_reg == bpc_pkg::BPC_ST_SHUT;
  wire react_ok = REACT_BELOW & ~ov_event;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      bpc_pkg::BPC_ST_RUN: begin
        if (ov_event) begin
          state_next = bpc_pkg::BPC_ST_SHUT;
        end
      end
      bpc_pkg::BPC_ST_SHUT: begin
        if (react_ok) begin
          state_next = bpc_pkg::BPC_ST_RUN;
        end
      end
      default: begin
        state_next = bpc_pkg::BPC_ST_SHUT;
      end
    endcase
  end

  // set wins over the clear on read
  assign ovf_next = ov_event | (ovf_reg & ~(rd_status & in_run));

  // ----------------------------------------------------------------
  // gate
  // ----------------------------------------------------------------
  wire gate_kill = ~ctl_en | ov_event | in_shut | ILIM_REACHED |
                   PEAK_REACHED | int_last;
  assign gate_next = gate_kill ? 1'b0 :
                     cycle_start ? 1'b1 : gate_reg;

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  wire [1:0] irq_set;
  assign irq_set[`BPC_IRQ_OV] = in_run & ov_event;
  assign irq_set[`BPC_IRQ_ILIM] = gate_reg & ILIM_REACHED;
  wire [1:0] irq_clr = (wr & hit_irq_stat) ? wmask[1:0] : 2'b00;
  assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
  assign irq_mask_next = (wr & hit_irq_mask) ? wmask[1:0] : irq_mask_reg;

  // ----------------------------------------------------------------
  // register writes and read mux
  // ----------------------------------------------------------------
  assign ctrl_next = (wr & hit_ctrl) ?
    ((ctrl_reg & ~lane_mask) | wmask) : ctrl_reg;
  assign prot_next = (wr & hit_prot) ?
    ((prot_reg & ~lane_mask) | wmask) : prot_reg;
  assign target_next = (wr & hit_target & PSTRB[0]) ?
    PWDATA[TARGET_W-1:0] : target_reg;

  wire [31:0] ctrl_rd = {19'h0, ctrl_reg[`BPC_CTRL_FREQ_LSB +: FREQ_W],
                         5'h00, ctl_inv, ctl_src, ctl_en};
  wire [31:0] prot_rd = {18'h0, prot_reg[`BPC_PROT_ILIM_LSB +: 2],
                         2'h0, prot_reg[`BPC_PROT_SLOPE_LSB +: 2],
                         2'h0, prot_reg[`BPC_PROT_HYST_LSB +: 2],
                         1'b0, prot_reg[`BPC_PROT_MARGIN_LSB +: 3]};
  wire [31:0] status_rd = {29'h0, in_shut, ovf_reg,
                           ctl_en & in_run};
  wire [31:0] target_rd = {{(32 - TARGET_W){1'b0}}, target_reg};

  assign prdata_next = !setup ? prdata_reg :
    hit_ctrl ? ctrl_rd :
    hit_target ? target_rd :
    hit_prot ? prot_rd :
    hit_status ? status_rd :
    hit_irq_stat ? {30'h0, irq_stat_reg} :
    hit_irq_mask ? {30'h0, irq_mask_reg} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // flops
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= `BPC_CTRL_RST;
      target_reg <= `BPC_TARGET_RST;
      prot_reg <= `BPC_PROT_RST;
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= `BPC_IRQ_MASK_RST;
      ovf_reg <= 1'b0;
      state_reg <= bpc_pkg::BPC_ST_RUN;
      cnt_reg <= 8'h00;
      gate_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      target_reg <= target_next;
      prot_reg <= prot_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      ovf_reg <= ovf_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      gate_reg <= gate_next;
      prdata_reg <= prdata_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = prdata_reg;
  assign GATE = gate_reg;
  assign RUN_STATUS = ctl_en & in_run;
  assign IRQ = |(irq_stat_reg & irq_mask_reg);
  assign TARGET_CODE = target_reg;
  assign OV_MARGIN = prot_reg[`BPC_PROT_MARGIN_LSB +: 3];
  assign REACT_HYST = prot_reg[`BPC_PROT_HYST_LSB +: 2];
  assign SLOPE_SEL = prot_reg[`BPC_PROT_SLOPE_LSB +: 2];
  assign ILIM_SEL = prot_reg[`BPC_PROT_ILIM_LSB +: 2];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_GATE_NEEDS_EN: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !ctl_en |=> !GATE)
    else $error("gate high while converter disabled");

  AST_OV_SHUTS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    OV_ABOVE |=> !GATE && ovf_reg && !RUN_STATUS)
    else $error("overvoltage did not stop gate and set flag");

  AST_OV_WHILE_OFF: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !ctl_en && OV_ABOVE |=> ovf_reg && in_shut)
    else $error("overvoltage missed while disabled");

  AST_LOW_FB: assert property (
    @(posedge CLK) disable iff (!RST_N)
    LOW_FB_DETECT_EN && LOW_FB |=> ovf_reg && !GATE)
    else $error("low feedback did not stop converter");

  AST_HOLD_UNTIL_REACT: assert property (
    @(posedge CLK) disable iff (!RST_N)
    in_shut && !REACT_BELOW |=> in_shut && !GATE)
    else $error("left shutdown before reactivation");

  AST_REACT_RESUMES: assert property (
    @(posedge CLK) disable iff (!RST_N)
    in_shut && REACT_BELOW && !OV_ABOVE && !LOW_FB |=> in_run)
    else $error("reactivation did not resume");

  AST_FLAG_STICKY: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ovf_reg && (in_shut || OV_ABOVE) |=> ovf_reg)
    else $error("overvoltage flag lost during overvoltage");

  AST_FLAG_CLEARS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    rd_status && in_run && !OV_ABOVE && !LOW_FB |=> !ovf_reg)
    else $error("overvoltage flag not cleared by read");

  AST_RUN_LOW_SHUT: assert property (
    @(posedge CLK) disable iff (!RST_N)
    in_shut |-> !RUN_STATUS)
    else $error("run status high during shutdown");

  AST_ILIM_CUTS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ILIM_REACHED |=> !GATE)
    else $error("current limit did not end on-time");

  AST_CODE_ZERO_STOPS: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !ctl_src && freq_code == '0 |-> !cycle_start ##1 cnt_reg == 8'h00)
    else $error("internal timing ran with code zero");

  AST_PERIOD_WRAP: assert property (
    @(posedge CLK) disable iff (!RST_N)
    int_run && cnt_reg == period_m1 && $stable(freq_code)
    |=> cnt_reg == 8'h00)
    else $error("divider missed its period");

  AST_EXT_EDGE_START: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ctl_src && ctl_en && in_run && !gate_kill &&
    (ctl_inv ? sync_fall : sync_rise) |=> GATE)
    else $error("selected sync edge did not start a cycle");

  AST_EXT_IGNORES_OTHER: assert property (
    @(posedge CLK) disable iff (!RST_N)
    ctl_src && !GATE && !(ctl_inv ? sync_fall : sync_rise) |=> !GATE)
    else $error("gate started without selected sync edge");

endmodule : bpc_top

//--- verif/bpc_stage_model.sv
// power stage model: inductor current sense seen by the gate driver
// assumes gate is the registered gate output of the block
`timescale 1ns/1ps

module bpc_stage_model (
  input wire logic clk,
  input wire logic gate,
  input wire logic [7:0] ramp_len,
  output logic peak
);
  // --------------------
  // current ramp
  // --------------------
  logic [7:0] ramp_reg;

  // current rises only while the switch is on, peak after ramp_len cycles
  always_ff @(posedge clk) begin
    if (gate) begin
      ramp_reg <= ramp_reg + 8'h01;
    end else begin
      ramp_reg <= 8'h00;
    end
  end
  assign peak = gate && (ramp_reg >= ramp_len);
endmodule : bpc_stage_model

//--- verif/boost_pwm_control_tb.sv
// testbench of the boost pwm control block, apb host side
// assumes bpc_top with default parameters and the stage model beside it
`timescale 1ns/1ps
`include "bpc_params.svh"

module boost_pwm_control_tb;
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } bpc_row_t;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sync_in = 1'b0, ov_above = 1'b0, react_below = 1'b1;
  logic low_fb = 1'b0, ilim = 1'b0, pready, pslverr, gate, run, irq, peak, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] pstrb = 4'hf;
  logic [7:0] ramp_len = 8'h03;
  logic [6:0] tgt;
  logic [2:0] mar;
  logic [1:0] hy, sl, il;
  int n_errors = 0, checked = 0, cycles = 0, lat;
  bpc_row_t rows[7];
  logic [4:0] codes[3] = '{5'h1f, 5'h01, 5'h10};
  int pers[3] = '{40, 190, 115};

  always #12.5 clk = ~clk;

  bpc_top DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SYNC_IN(sync_in),
    .OV_ABOVE(ov_above), .REACT_BELOW(react_below), .LOW_FB(low_fb),
    .PEAK_REACHED(peak), .ILIM_REACHED(ilim), .GATE(gate),
    .RUN_STATUS(run), .IRQ(irq), .TARGET_CODE(tgt), .OV_MARGIN(mar),
    .REACT_HYST(hy), .SLOPE_SEL(sl), .ILIM_SEL(il));

  bpc_stage_model stage (.clk(clk), .gate(gate), .ramp_len(ramp_len),
    .peak(peak));

  // --------------------
  // tasks
  // --------------------
  task automatic close_out;
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic wait_gate(input int lim);
    lat = 0;
    while (gate !== 1'b1 && lat < lim) begin
      @(posedge clk);
      lat++;
    end
  endtask : wait_gate

  // counts cycles from the call to the next gate rise, first waiting out a gate that is already high
  task automatic wait_rise(input int lim);
    lat = 0;
    while (gate === 1'b1 && lat < lim) begin
      @(posedge clk);
      lat++;
    end
    while (gate !== 1'b1 && lat < lim) begin
      @(posedge clk);
      lat++;
    end
  endtask : wait_rise

  task automatic quiet(input int n);
    lat = 0;
    repeat (n) begin
      @(posedge clk);
      if (gate === 1'b1) lat++;
    end
  endtask : quiet

  // --------------------
  // sequence
  // --------------------
  initial begin
    rows[0] = '{`BPC_OFF_TARGET, 32'hffff_ffff, 32'h0000_007f, 1'b0};
    rows[1] = '{`BPC_OFF_PROT, 32'hffff_ffff, 32'h0000_3337, 1'b0};
    rows[2] = '{`BPC_OFF_IRQ_MASK, 32'hffff_ffff, 32'h0000_0003, 1'b0};
    rows[3] = '{`BPC_OFF_CTRL, 32'h0000_1f06, 32'h0000_1f06, 1'b0};
    rows[4] = '{`BPC_OFF_STATUS, 32'hffff_ffff, 32'h0000_0000, 1'b0};
    rows[5] = '{`BPC_OFF_IRQ_STAT, 32'hffff_ffff, 32'h0000_0000, 1'b0};
    rows[6] = '{12'h018, 32'hffff_ffff, 32'h0000_0000, 1'b1};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      rd(rows[i].a, 32'h0);
      wr(rows[i].a, rows[i].d);
      chk({30'h0, pready, e}, {30'h0, 1'b1, rows[i].e});
      rd(rows[i].a, rows[i].q);
    end
    chk({16'h0, tgt, mar, hy, sl, il}, 32'h0000_ffff);
    pstrb <= 4'he;
    wr(`BPC_OFF_TARGET, 32'h0);
    pstrb <= 4'hf;
    rd(`BPC_OFF_TARGET, 32'h0000_007f);
    ramp_len <= 8'hff;
    for (int i = 0; i < 3; i++) begin
      wr(`BPC_OFF_CTRL, {19'h0, codes[i], 8'h01});
      wait_rise(400);
      wait_rise(400);
      chk(lat, pers[i]);
    end
    wr(`BPC_OFF_CTRL, 32'h0000_1f00);
    quiet(200);
    chk(lat, 0);
    wr(`BPC_OFF_CTRL, 32'h0000_0001);
    quiet(300);
    chk(lat, 0);
    ramp_len <= 8'h03;
    for (int v = 0; v < 2; v++) begin
      wr(`BPC_OFF_CTRL, {29'h0, v[0], 2'b11});
      for (int j = 0; j < 2; j++) begin
        sync_in <= ~sync_in;
        wait_gate(12);
        chk(32'(lat >= 2 && lat < 9), 32'((j == 0) ^ v[0]));
        repeat (12) @(posedge clk);
      end
    end
    sync_in <= 1'b1;
    @(posedge clk);
    sync_in <= 1'b0;
    quiet(20);
    chk(lat, 0);
    ramp_len <= 8'hff;
    wr(`BPC_OFF_CTRL, 32'h0000_1f01);
    wr(`BPC_OFF_IRQ_MASK, 32'h0);
    wait_gate(100);
    ov_above <= 1'b1;
    react_below <= 1'b0;
    repeat (2) @(posedge clk);
    chk({29'h0, gate, run, irq}, 32'h0);
    rd(`BPC_OFF_STATUS, 32'h0000_0006);
    wr(`BPC_OFF_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    ov_above <= 1'b0;
    quiet(200);
    chk(lat, 0);
    rd(`BPC_OFF_STATUS, 32'h0000_0006);
    react_below <= 1'b1;
    wait_gate(200);
    chk(32'(lat < 200), 32'h1);
    chk({31'h0, run}, 32'h1);
    rd(`BPC_OFF_STATUS, 32'h0000_0003);
    rd(`BPC_OFF_STATUS, 32'h0000_0001);
    wr(`BPC_OFF_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wait_rise(200);
    ilim <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, gate}, 32'h0);
    ilim <= 1'b0;
    rd(`BPC_OFF_IRQ_STAT, 32'h0000_0002);
    wait_rise(200);
    low_fb <= 1'b1;
    repeat (2) @(posedge clk);
    chk({30'h0, gate, run}, 32'h0);
    low_fb <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`BPC_OFF_STATUS, 32'h0000_0003);
    wr(`BPC_OFF_CTRL, 32'h0);
    ov_above <= 1'b1;
    repeat (3) @(posedge clk);
    ov_above <= 1'b0;
    repeat (3) @(posedge clk);
    rd(`BPC_OFF_STATUS, 32'h0000_0002);
    rd(`BPC_OFF_STATUS, 32'h0000_0000);
    wr(`BPC_OFF_CTRL, 32'h0000_1f01);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({29'h0, gate, run, irq}, 32'h0);
    rst_n <= 1'b1;
    ov_above <= 1'b1;
    @(posedge clk);
    ov_above <= 1'b0;
    rd(`BPC_OFF_CTRL, 32'h0);
    rd(`BPC_OFF_TARGET, 32'h0);
    rd(`BPC_OFF_STATUS, 32'h0000_0002);
    close_out();
  end
endmodule : boost_pwm_control_tb
